// *** core/rtcca_defs.vh ***
// Purpose: register map, field positions, reset values and codes of the counter control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef RTCCA_DEFS_VH
`define RTCCA_DEFS_VH

// register byte offsets
`define RTCCA_OFF_CTRL 8'h00
`define RTCCA_OFF_SYNC 8'h04
`define RTCCA_OFF_FLAG 8'h08
`define RTCCA_OFF_FCLR 8'h0C
`define RTCCA_OFF_FEN 8'h10
`define RTCCA_OFF_COUNT 8'h14
`define RTCCA_OFF_ALARM 8'h18
`define RTCCA_OFF_DBG 8'h1C

// control word field positions
`define RTCCA_B_SOFT_RESET_REQUEST 0
`define RTCCA_B_ENABLE 1
`define RTCCA_B_MODE_LO 2
`define RTCCA_B_MODE_HI 3
`define RTCCA_B_FMT 6
`define RTCCA_B_COM 7

// sync status and flag positions
`define RTCCA_B_SYNC_SOFT_RESET_REQUEST 0
`define RTCCA_B_SYNC_EN 1
`define RTCCA_B_FLAG_ALARM 0
`define RTCCA_B_FLAG_OVF 1

// operating mode codes
`define RTCCA_MODE_WIDE 2'h0
`define RTCCA_MODE_NARROW 2'h1
`define RTCCA_MODE_CLOCK 2'h2

// reset values
`define RTCCA_RST_WORD 32'h0000_0000
`define RTCCA_RST_MODE 2'h0

// time of day limits in clock mode: sec [5:0], min [11:6], hour [16:12]
`define RTCCA_SEC_MAX 6'h3B
`define RTCCA_MIN_MAX 6'h3B
`define RTCCA_HOUR_MAX 5'h17
`define RTCCA_HOUR_NOON 5'h0C

`endif

// *** core/rtcca_handshake.v ***
// Purpose: request/acknowledge toggle handshake toward the counter side and back
// Assumes: one start pulse at a time; start is ignored while busy
// Notes: done pulses one cycle when the far side has acknowledged
`timescale 1ns/1ns

module rtcca_handshake (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // request
  input wire start,
  // status
  output wire busy,
  output wire done
);

  reg req_q;
  reg far_a_q;
  reg far_b_q;
  reg ack_a_q;
  reg ack_b_q;
  reg seen_q;

  // request toggle, carried over and returned through two-flop stages
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      far_a_q <= 1'b0;
      far_b_q <= 1'b0;
      ack_a_q <= 1'b0;
      ack_b_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (start && !busy) begin
        req_q <= ~req_q;
      end
      far_a_q <= req_q;
      far_b_q <= far_a_q;
      ack_a_q <= far_b_q;
      ack_b_q <= ack_a_q;
      seen_q <= ack_b_q;
    end
  end

  // busy until the returned toggle has been consumed
  assign busy = req_q ^ seen_q;
  assign done = ack_b_q ^ seen_q;

endmodule

// *** core/rtcca_ctrl.v ***
// Purpose: control word, mode logic, counter and APB slave of a real-time counter
// Assumes: count_tick is a one-cycle pulse per counter clock edge, synchronous to core_clk
// Notes: enable and soft reset pass a request/ack handshake before they act
`timescale 1ns/1ns
`include "rtcca_defs.vh"

// Summary of operation
// - clear counter on alarm match when set
// - hour format 24h or 12h, clock mode
// - hour format written only while disabled
// - mode field selects wide, narrow, clock counting
// - mode writes act directly, no busy flag
// - enable reads back at once, busy set
// - enable busy clears when operation completes
// - soft reset restores all but debug control
// - soft reset write discards other fields
// - soft reset bit stays until reset done
// - clear on match: wide, clock modes, disabled
// - clearing match sets alarm and overflow together
// - only power-on or soft reset resets
module rtcca_ctrl (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // counter side
  input wire count_tick,
  input wire dbg_halt,
  // status and interrupt
  output wire counter_running,
  output wire irq
);

  reg rst_a_q;
  reg rst_b_q;
  wire rst_n;
  reg clear_on_match_q;
  reg hour_format_select_q;
  reg [1:0] mode_q;
  reg enable_q;
  reg en_active_q;
  reg dbg_run_q;
  reg [31:0] alarm_q;
  reg [31:0] count_q;
  reg [31:0] count_d;
  reg flag_alarm_q;
  reg flag_ovf_q;
  reg [1:0] flag_en_q;
  reg [31:0] rdata_d;
  reg err_d;
  wire wr_acc;
  wire setup;
  wire ctrl_wr;
  wire soft_reset;
  wire en_busy;
  wire en_done;
  wire sr_busy;
  wire sr_done;
  wire ticking;
  wire match;
  wire com_ok;
  reg wrap;
  wire clr_match;
  wire [31:0] flag_word;

  // reset release through two flip-flops
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  assign rst_n = rst_b_q;

  // next clock-mode time of day, 24h encoding
  function [31:0] tod_next;
    input [31:0] t;
    begin
      tod_next = 32'h0000_0000;
      if (t[5:0] != `RTCCA_SEC_MAX) begin
        tod_next = {t[31:6], t[5:0] + 6'h01};
      end else if (t[11:6] != `RTCCA_MIN_MAX) begin
        tod_next = {t[31:12], t[11:6] + 6'h01, 6'h00};
      end else if (t[16:12] != `RTCCA_HOUR_MAX) begin
        tod_next = {t[31:17], t[16:12] + 5'h01, 12'h000};
      end
    end
  endfunction

  // clock value as read: hours in 12h am/pm form when selected
  function [31:0] tod_view;
    input [31:0] t;
    input fmt;
    reg [4:0] h;
    begin
      h = t[16:12];
      tod_view = t;
      if (fmt) begin
        if (h == 5'h00) begin
          tod_view[16:12] = `RTCCA_HOUR_NOON;
        end else if (h > `RTCCA_HOUR_NOON) begin
          tod_view[16:12] = {1'b1, h[3:0] - 4'hC}; // pm, 13..23 -> 1..11
        end else if (h == `RTCCA_HOUR_NOON) begin
          tod_view[16:12] = {1'b1, 4'hC};
        end
      end
    end
  endfunction

  // bus phases
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = psel && penable;
  assign ctrl_wr = wr_acc && (paddr == `RTCCA_OFF_CTRL) && !sr_busy && !en_busy;
  assign soft_reset = ctrl_wr && pwdata[`RTCCA_B_SOFT_RESET_REQUEST];

  // handshakes toward the counter side
  rtcca_handshake u_en_hs (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(ctrl_wr && !pwdata[`RTCCA_B_SOFT_RESET_REQUEST] && (pwdata[`RTCCA_B_ENABLE] != enable_q)),
    .busy(en_busy),
    .done(en_done)
  );

  rtcca_handshake u_sr_hs (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(soft_reset),
    .busy(sr_busy),
    .done(sr_done)
  );

  // control word; soft reset completion restores every field but debug control
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_on_match_q <= 1'b0;
      hour_format_select_q <= 1'b0;
      mode_q <= `RTCCA_RST_MODE;
      enable_q <= 1'b0;
      en_active_q <= 1'b0;
      dbg_run_q <= 1'b0;
      alarm_q <= `RTCCA_RST_WORD;
      flag_en_q <= 2'h0;
    end else if (sr_done) begin
      clear_on_match_q <= 1'b0;
      hour_format_select_q <= 1'b0;
      mode_q <= `RTCCA_RST_MODE;
      enable_q <= 1'b0;
      en_active_q <= 1'b0;
      alarm_q <= `RTCCA_RST_WORD;
      flag_en_q <= 2'h0;
    end else begin
      if (ctrl_wr && !soft_reset) begin
        mode_q <= pwdata[`RTCCA_B_MODE_HI:`RTCCA_B_MODE_LO];
        enable_q <= pwdata[`RTCCA_B_ENABLE];
        if (!enable_q && !en_active_q) begin
          clear_on_match_q <= pwdata[`RTCCA_B_COM];
          hour_format_select_q <= pwdata[`RTCCA_B_FMT];
        end
      end
      if (en_done && !sr_busy) begin
        en_active_q <= enable_q;
      end
      if (wr_acc && paddr == `RTCCA_OFF_ALARM) begin
        alarm_q <= pwdata;
      end
      if (wr_acc && paddr == `RTCCA_OFF_FEN) begin
        flag_en_q <= pwdata[1:0];
      end
      if (wr_acc && paddr == `RTCCA_OFF_DBG) begin
        dbg_run_q <= pwdata[0];
      end
    end
  end

  // counting conditions, match and wrap per mode
  assign ticking = count_tick && en_active_q && (!dbg_halt || dbg_run_q);
  assign match = (mode_q == `RTCCA_MODE_NARROW) ? (count_q[15:0] == alarm_q[15:0])
                                                : (count_q == alarm_q);
  assign com_ok = clear_on_match_q && (mode_q != `RTCCA_MODE_NARROW);
  assign clr_match = ticking && match && com_ok;

  // next counter value
  always @* begin
    count_d = count_q;
    wrap = 1'b0;
    case (mode_q)
      `RTCCA_MODE_WIDE: begin
        wrap = (count_q == 32'hFFFF_FFFF);
        count_d = count_q + 32'h0000_0001;
      end
      `RTCCA_MODE_NARROW: begin
        wrap = (count_q[15:0] == 16'hFFFF);
        count_d = {16'h0000, count_q[15:0] + 16'h0001};
      end
      `RTCCA_MODE_CLOCK: begin
        wrap = (count_q[16:0] == {`RTCCA_HOUR_MAX, `RTCCA_MIN_MAX, `RTCCA_SEC_MAX});
        count_d = tod_next(count_q);
      end
      default: begin
        wrap = 1'b0; // reserved mode holds the count
      end
    endcase
    if (clr_match) begin
      count_d = 32'h0000_0000;
    end
  end

  // counter register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `RTCCA_RST_WORD;
    end else if (sr_done) begin
      count_q <= `RTCCA_RST_WORD;
    end else if (ticking && mode_q != 2'h3) begin
      count_q <= count_d;
    end
  end

  // sticky flags: the set wins over a clear in the same cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_alarm_q <= 1'b0;
      flag_ovf_q <= 1'b0;
    end else if (sr_done) begin
      flag_alarm_q <= 1'b0;
      flag_ovf_q <= 1'b0;
    end else begin
      if (ticking && match) begin
        flag_alarm_q <= 1'b1;
      end else if (wr_acc && paddr == `RTCCA_OFF_FCLR && pwdata[`RTCCA_B_FLAG_ALARM]) begin
        flag_alarm_q <= 1'b0;
      end
      if ((ticking && wrap && mode_q != 2'h3) || clr_match) begin
        flag_ovf_q <= 1'b1;
      end else if (wr_acc && paddr == `RTCCA_OFF_FCLR && pwdata[`RTCCA_B_FLAG_OVF]) begin
        flag_ovf_q <= 1'b0;
      end
    end
  end

  assign flag_word = {30'h0000_0000, flag_ovf_q, flag_alarm_q};
  assign irq = |(flag_word[1:0] & flag_en_q);
  assign counter_running = en_active_q;

  // read mux and address check
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `RTCCA_OFF_CTRL: begin
        rdata_d = {24'h00_0000, clear_on_match_q, hour_format_select_q, 2'h0,
                   mode_q, enable_q, sr_busy};
      end
      `RTCCA_OFF_SYNC: begin
        rdata_d = {30'h0000_0000, en_busy, sr_busy};
      end
      `RTCCA_OFF_FLAG: begin
        rdata_d = flag_word;
      end
      `RTCCA_OFF_FCLR: begin
        rdata_d = 32'h0000_0000;
      end
      `RTCCA_OFF_FEN: begin
        rdata_d = {30'h0000_0000, flag_en_q};
      end
      `RTCCA_OFF_COUNT: begin
        rdata_d = (mode_q == `RTCCA_MODE_CLOCK) ?
                  tod_view(count_q, hour_format_select_q) : count_q;
      end
      `RTCCA_OFF_ALARM: begin
        rdata_d = alarm_q;
      end
      `RTCCA_OFF_DBG: begin
        rdata_d = {31'h0000_0000, dbg_run_q};
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // read data and error captured in the setup cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= err_d;
    end
  end

endmodule

// *** verification/rtcca_properties.sv ***
// Purpose: port-level properties of the counter control block
// Assumes: zero-wait apb slave, five-edge enable and soft reset handshake
// Notes: bound to rtcca_ctrl after the module
`timescale 1ns/1ns
module rtcca_checker (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // counter side and status
  input wire count_tick,
  input wire dbg_halt,
  input wire counter_running,
  input wire irq
);
  logic [3:0] gap_q;
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == 8'h00;
  wire wr_flag = acc && pwrite && (paddr == 8'h0C || paddr == 8'h10);
  wire rd_late = acc && !pwrite && gap_q > 4'h9;

  // cycles since the last control write, saturating so idle never looks recent
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= 4'hf;
    end else if (wr_ctrl) begin
      gap_q <= 4'h0;
    end else if (gap_q != 4'hf) begin
      gap_q <= gap_q + 4'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ready_zero_wait_a: assert property (pready == acc)
    else $error("pready differs from access phase");
  addr_err_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1C))
    else $error("pslverr wrong for address");
  run_rise_a: assert property ($rose(counter_running) |-> gap_q inside {[4:6]})
    else $error("counter started outside handshake window");
  run_fall_a: assert property ($fell(counter_running) |-> gap_q inside {[4:6]})
    else $error("counter stopped outside handshake window");
  sync_idle_a: assert property (rd_late && paddr == 8'h04 |-> prdata[1:0] == 2'h0)
    else $error("busy still set long after control write");
  soft_reset_request_done_a: assert property (rd_late && paddr == 8'h00 |-> !prdata[0])
    else $error("soft reset bit not cleared");
  irq_rise_a: assert property ($rose(irq) |-> $past(count_tick) || $past(wr_flag))
    else $error("irq rose without tick or enable write");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_flag) || gap_q inside {[4:6]})
    else $error("irq fell without clear or soft reset");

  cover property (wr_ctrl && pwdata[1]);
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule

bind rtcca_ctrl rtcca_checker rtcca_checker_inst (.core_clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .count_tick, .dbg_halt,
  .counter_running, .irq);

// *** verification/tb_rtc_control_a_logic.sv ***
// Purpose: self-checking bench for the counter control block
// Assumes: zero-wait apb slave, handshake done well within ten cycles
// Notes: alarm values of the mode test come from a fixed-seed shift register
`timescale 1ns/1ns
module tb_rtc_control_a_logic;
  logic core_clk = 0;
  logic arst_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, count_tick = 0, dbg_halt = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  wire pready, pslverr, counter_running, irq;
  wire [31:0] prdata;
  logic [31:0] rv, a;
  logic [31:0] seed = 32'hbade_e0da;
  logic err_seen;
  int error_cnt = 0, n_tests = 0;

  // device under test
  rtcca_ctrl rtcca_ctrl_inst (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .count_tick, .dbg_halt, .counter_running, .irq);

  always #10 core_clk = ~core_clk;

  // random source and expected control word
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [31:0] ctl(input [1:0] m, input en, input com, input fmt);
    return {24'h0, com, fmt, 2'h0, m, en, 1'b0};
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(rv, e);
  endtask
  // counter clock pulses and handshake wait
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      count_tick <= 1'b1;
      @(posedge core_clk);
      count_tick <= 1'b0;
    end
  endtask
  task automatic settle;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #400000;
    error_cnt++;
    complete_run;
  end

  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // reset values and an unmapped address
    for (int i = 0; i < 8; i++)
      if (i != 3) rdc(8'(i * 4), 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    $display("reset test done");
    // fields written while disabled, then enable with busy
    apb(1'b1, 8'h00, ctl(2'h2, 1'b0, 1'b1, 1'b0));
    rdc(8'h04, 32'h0);
    rdc(8'h00, ctl(2'h2, 1'b0, 1'b1, 1'b0));
    apb(1'b1, 8'h00, ctl(2'h2, 1'b1, 1'b1, 1'b0));
    rdc(8'h04, 32'h2);
    chk({31'h0, counter_running}, 32'h0);
    rdc(8'h00, ctl(2'h2, 1'b1, 1'b1, 1'b0));
    settle;
    rdc(8'h04, 32'h0);
    chk({31'h0, counter_running}, 32'h1);
    // format and clear-on-match refused while enabled
    apb(1'b1, 8'h00, ctl(2'h2, 1'b1, 1'b0, 1'b1));
    rdc(8'h00, ctl(2'h2, 1'b1, 1'b1, 1'b0));
    $display("enable test done");
    // clock mode match clears count and raises both flags
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h10, 32'h3);
    tick(4);
    rdc(8'h14, 32'h0);
    rdc(8'h08, 32'h3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h0C, 32'h3);
    rdc(8'h08, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("match test done");
    // soft reset discards its other fields, debug run survives
    apb(1'b1, 8'h1C, 32'h1);
    apb(1'b1, 8'h00, 32'hcf);
    rdc(8'h00, ctl(2'h2, 1'b1, 1'b1, 1'b0) | 32'h1);
    settle;
    rdc(8'h00, 32'h0);
    rdc(8'h1C, 32'h1);
    rdc(8'h18, 32'h0);
    chk({31'h0, counter_running}, 32'h0);
    apb(1'b1, 8'h1C, 32'h0);
    $display("soft reset test done");
    // midnight reads as twelve am in clock mode, raw count in wide mode
    apb(1'b1, 8'h00, ctl(2'h2, 1'b1, 1'b0, 1'b1));
    settle;
    tick(2);
    rdc(8'h14, 32'h0000_c002);
    apb(1'b1, 8'h00, ctl(2'h0, 1'b1, 1'b0, 1'b1));
    rdc(8'h14, 32'h0000_0002);
    apb(1'b1, 8'h00, 32'h0000_0001);
    settle;
    $display("format test done");
    // counter modes with random alarm, halt and reserved mode hold
    for (int m = 0; m < 2; m++) begin
      seed = lfsr(seed);
      a = {29'h0, seed[2:0]};
      apb(1'b1, 8'h18, a);
      apb(1'b1, 8'h00, ctl(m[1:0], 1'b1, 1'b0, 1'b0));
      settle;
      tick(a + 2);
      rdc(8'h14, a + 2);
      rdc(8'h08, 32'h1);
      dbg_halt <= 1'b1;
      tick(1);
      dbg_halt <= 1'b0;
      apb(1'b1, 8'h00, ctl(2'h3, 1'b1, 1'b0, 1'b0));
      tick(2);
      rdc(8'h14, a + 2);
      apb(1'b1, 8'h00, 32'h1);
      settle;
    end
    $display("mode test done");
    complete_run;
  end
endmodule
